// ==== core/ara_ahb_port.sv ====
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/1ps
`default_nettype none
module ara_ahb_port
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // register side
    input wire logic [31:0] rd_data,
    output logic [31:0] acc_addr,
    output logic acc_write,
    output logic acc_pending
);
    // *****************************
    // address phase capture
    // *****************************
    wire take = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
            acc_addr <= 32'h0000_0000;
            acc_write <= 1'b0;
            acc_pending <= 1'b0;
        end
        else if (acc_pending)
        begin
            hreadyout <= 1'b1;
            acc_pending <= 1'b0;
            if (!acc_write)
                hrdata <= rd_data;
        end
        else if (take)
        begin
            hreadyout <= 1'b0;
            acc_pending <= 1'b1;
            acc_addr <= haddr;
            acc_write <= hwrite;
        end
    end
endmodule
`default_nettype wire

// ==== core/ara_justify.sv ====
// places a 10-bit result into high and low bytes by format
`timescale 1ns/1ps
`default_nettype none
module ara_justify
(
    // result and format
    input wire ara_pkg::ara_result_t result,
    input wire logic right_just,
    // aligned bytes
    output ara_pkg::ara_byte_t high_byte,
    output ara_pkg::ara_byte_t low_byte
);
    // *****************************
    // left: high gets 9..2, low gets 1..0 over zeros
    // right: high gets zeros over 9..8, low gets 7..0
    // *****************************
    wire ara_pkg::ara_byte_t left_high = result[9:2];
    wire ara_pkg::ara_byte_t left_low = {result[1:0], 6'h00};
    wire ara_pkg::ara_byte_t right_high = {6'h00, result[9:8]};
    wire ara_pkg::ara_byte_t right_low = result[7:0];

    assign high_byte = right_just ? right_high : left_high;
    assign low_byte = right_just ? right_low : left_low;
endmodule
`default_nettype wire

// ==== core/ara_top.sv ====
// converter result registers with format alignment behind AHB-Lite
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ara_defines.svh"

module ara_top
#(
    parameter int ACQ_CYCLES = `ARA_ACQ_CYCLES,
    parameter int ACQ_CNT_W = 8
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // converter core
    input wire logic conv_done,
    input wire ara_pkg::ara_result_t conv_result,
    // converter controls
    output logic result_format_select,
    output logic [4:0] input_channel_select,
    output logic acq_elapsed
);
    // *****************************
    // parameter checks
    // *****************************
    if (ACQ_CYCLES < 1 || ACQ_CYCLES >= (1 << ACQ_CNT_W))
    begin : g_bad_acq
        $error("acquisition count does not fit its counter");
    end

    // *****************************
    // bus front end
    // *****************************
    logic [31:0] acc_addr;
    logic acc_write;
    logic acc_pending;
    logic [31:0] rd_data;

    ara_ahb_port u_port
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .rd_data(rd_data),
        .acc_addr(acc_addr),
        .acc_write(acc_write),
        .acc_pending(acc_pending)
    );

    // *****************************
    // address decode
    // *****************************
    function automatic ara_pkg::ara_sel_t decode_sel(input logic [31:0] addr);
        case (addr)
            `ARA_OFF_HIGH: decode_sel = ara_pkg::ARA_SEL_HIGH;
            `ARA_OFF_LOW: decode_sel = ara_pkg::ARA_SEL_LOW;
            `ARA_OFF_CTRL: decode_sel = ara_pkg::ARA_SEL_CTRL;
            `ARA_OFF_STAT: decode_sel = ara_pkg::ARA_SEL_STAT;
            default: decode_sel = ara_pkg::ARA_SEL_NONE;
        endcase
    endfunction

    wire ara_pkg::ara_sel_t sel = decode_sel(acc_addr);
    wire wr_en = acc_pending && acc_write;
    wire wr_high = wr_en && (sel == ara_pkg::ARA_SEL_HIGH);
    wire wr_low = wr_en && (sel == ara_pkg::ARA_SEL_LOW);
    wire wr_ctrl = wr_en && (sel == ara_pkg::ARA_SEL_CTRL);
    wire wr_stat = wr_en && (sel == ara_pkg::ARA_SEL_STAT);
    wire [4:0] wr_chs = hwdata[`ARA_CTRL_CHS_MSB:`ARA_CTRL_CHS_LSB];
    wire ch_change = wr_ctrl && (wr_chs != input_channel_select);

    // *****************************
    // result alignment
    // *****************************
    ara_pkg::ara_byte_t result_high_byte;
    ara_pkg::ara_byte_t result_low_byte;
    ara_pkg::ara_byte_t aligned_high;
    ara_pkg::ara_byte_t aligned_low;

    ara_justify u_justify
    (
        .result(conv_result),
        .right_just(result_format_select),
        .high_byte(aligned_high),
        .low_byte(aligned_low)
    );

    // *****************************
    // result bytes: no reset, a load beats a software write
    // *****************************
    wire ara_pkg::ara_byte_t next_high = conv_done ? aligned_high : hwdata[7:0];
    wire ara_pkg::ara_byte_t next_low = conv_done ? aligned_low : hwdata[7:0];

    always_ff @(posedge hclk)
    begin
        if (conv_done || wr_high)
            result_high_byte <= next_high;
        if (conv_done || wr_low)
            result_low_byte <= next_low;
    end

    // *****************************
    // control, acquisition timer and status
    // *****************************
    logic [ACQ_CNT_W-1:0] acq_cnt;
    logic result_fresh;
    wire acq_last = (acq_cnt == ACQ_CNT_W'(ACQ_CYCLES - 1));
    wire fresh_clear = wr_stat && hwdata[`ARA_STAT_FRESH_BIT];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            result_format_select <= `ARA_FMT_RESET;
            input_channel_select <= `ARA_CHS_RESET;
        end
        else if (wr_ctrl)
        begin
            result_format_select <= hwdata[`ARA_CTRL_FMT_BIT];
            input_channel_select <= wr_chs;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acq_cnt <= '0;
            acq_elapsed <= 1'b0;
        end
        else if (ch_change)
        begin
            acq_cnt <= '0;
            acq_elapsed <= 1'b0;
        end
        else if (!acq_elapsed)
        begin
            if (acq_last)
                acq_elapsed <= 1'b1;
            else
                acq_cnt <= ACQ_CNT_W'(acq_cnt + 1'b1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            result_fresh <= 1'b0;
        else if (conv_done)
            result_fresh <= 1'b1;
        else if (fresh_clear)
            result_fresh <= 1'b0;
    end

    // *****************************
    // read mux
    // *****************************
    wire [31:0] ctrl_word = {26'h0, input_channel_select, result_format_select};
    wire [31:0] stat_word = {30'h0, result_fresh, acq_elapsed};

    assign rd_data = (sel == ara_pkg::ARA_SEL_HIGH) ? {24'h0, result_high_byte} :
                     (sel == ara_pkg::ARA_SEL_LOW) ? {24'h0, result_low_byte} :
                     (sel == ara_pkg::ARA_SEL_CTRL) ? ctrl_word :
                     (sel == ara_pkg::ARA_SEL_STAT) ? stat_word : 32'h0000_0000;

    // *****************************
    // assertions
    // *****************************
    wire load_left = conv_done && !result_format_select;
    wire load_right = conv_done && result_format_select;

    a_left_high_fill: assert property (
        @(posedge hclk) disable iff (!hresetn)
        load_left |=> result_high_byte == $past(conv_result[9:2]))
        else $error("left load high byte wrong");

    a_left_low_pad: assert property (
        @(posedge hclk) disable iff (!hresetn)
        load_left |=> result_low_byte[7:6] == $past(conv_result[1:0]))
        else $error("left load low bits 7..6 wrong");

    a_left_low_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        load_left |=> result_low_byte[5:0] == 6'h00)
        else $error("left load did not clear low bits");

    a_right_high_bits: assert property (
        @(posedge hclk) disable iff (!hresetn)
        load_right |=> result_high_byte[1:0] == $past(conv_result[9:8]))
        else $error("right load high bits 1..0 wrong");

    a_right_high_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        load_right |=> result_high_byte[7:2] == 6'h00)
        else $error("right load did not clear high bits");

    a_right_low_fill: assert property (
        @(posedge hclk) disable iff (!hresetn)
        load_right |=> result_low_byte == $past(conv_result[7:0]))
        else $error("right load low byte wrong");

    a_sw_write_held: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_low && !conv_done) ##1 (!conv_done && !wr_low)[*2]
        |-> result_low_byte == $past(hwdata[7:0], 2))
        else $error("software write to low byte lost");

    a_format_no_rearrange: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_ctrl && !conv_done) |=> $stable(result_high_byte) && $stable(result_low_byte))
        else $error("format change altered held result");

    a_read_back_low: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (acc_pending && !acc_write && sel == ara_pkg::ARA_SEL_LOW)
        |=> hrdata == {24'h0, $past(result_low_byte)} && hreadyout)
        else $error("low byte read returned wrong data");

    a_acq_restart: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ch_change |=> !acq_elapsed && acq_cnt == '0)
        else $error("channel change did not restart acquisition");

    a_acq_length: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(acq_elapsed) |-> $past(acq_cnt) == ACQ_CNT_W'(ACQ_CYCLES - 1))
        else $error("acquisition period length wrong");

    a_one_wait: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (hsel && htrans[1] && hready && hreadyout) |=> !hreadyout ##1 hreadyout)
        else $error("transfer did not take exactly one wait state");
endmodule
`default_nettype wire

// ==== dv/adc_result_alignment_bench.sv ====
// self-checking bench for the converter result alignment block
`timescale 1ns/1ps
`default_nettype none
`include "ara_defines.svh"
module adc_result_alignment_bench;
    localparam int ACQ = 4;
    localparam int LIMIT = 5000;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic conv_done = 1'b0;
    ara_pkg::ara_result_t conv_result = 10'h000;
    wire logic hreadyout;
    wire logic [31:0] hrdata;
    wire logic hresp;
    wire logic result_format_select;
    wire logic [4:0] input_channel_select;
    wire logic acq_elapsed;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    ara_pkg::ara_result_t tbl [4] = '{10'h3FF, 10'h2A5, 10'h001, 10'h200};

    // *****************************
    // design under test
    // *****************************
    ara_top #(.ACQ_CYCLES(ACQ), .ACQ_CNT_W(8)) dut
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hreadyout),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .conv_done(conv_done),
        .conv_result(conv_result),
        .result_format_select(result_format_select),
        .input_channel_select(input_channel_select),
        .acq_elapsed(acq_elapsed)
    );

    always #12.5 hclk = ~hclk;

    // *****************************
    // bus and check tasks
    // *****************************
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask

    task automatic load(input ara_pkg::ara_result_t r);
        @(posedge hclk);
        conv_done <= 1'b1;
        conv_result <= r;
        @(posedge hclk);
        conv_done <= 1'b0;
    endtask

    task automatic rst;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fails++;
            summarize();
        end
    end

    // *****************************
    // test sequence
    // *****************************
    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(`ARA_OFF_CTRL, 32'h0);
        chk({31'h0, result_format_select}, 32'h0);
        foreach (tbl[i])
        begin
            wr(`ARA_OFF_LOW, 32'hFF);
            load(tbl[i]);
            rdchk(`ARA_OFF_HIGH, {24'h0, tbl[i][9:2]});
            rdchk(`ARA_OFF_LOW, {24'h0, tbl[i][1:0], 6'h00});
        end
        wr(`ARA_OFF_CTRL, 32'h1);
        chk({31'h0, result_format_select}, 32'h1);
        foreach (tbl[i])
        begin
            wr(`ARA_OFF_HIGH, 32'hFF);
            load(tbl[i]);
            rdchk(`ARA_OFF_HIGH, {24'h0, 6'h00, tbl[i][9:8]});
            rdchk(`ARA_OFF_LOW, {24'h0, tbl[i][7:0]});
        end
        wr(`ARA_OFF_CTRL, 32'h0);
        rdchk(`ARA_OFF_HIGH, {30'h0, tbl[3][9:8]});
        rdchk(`ARA_OFF_LOW, {24'h0, tbl[3][7:0]});
        wr(`ARA_OFF_HIGH, 32'h5A);
        wr(`ARA_OFF_LOW, 32'hC3);
        rdchk(`ARA_OFF_HIGH, 32'h5A);
        rdchk(`ARA_OFF_LOW, 32'hC3);
        rst();
        rdchk(`ARA_OFF_HIGH, 32'h5A);
        rdchk(`ARA_OFF_LOW, 32'hC3);
        rdchk(`ARA_OFF_CTRL, 32'h0);
        // two loads on consecutive edges, the last one stays
        @(posedge hclk);
        conv_done <= 1'b1;
        conv_result <= 10'h155;
        @(posedge hclk);
        conv_result <= 10'h0AA;
        @(posedge hclk);
        conv_done <= 1'b0;
        rdchk(`ARA_OFF_HIGH, 32'h2A);
        rdchk(`ARA_OFF_LOW, 32'h80);
        rdchk(`ARA_OFF_STAT, 32'h3);
        wr(`ARA_OFF_STAT, 32'h2);
        rdchk(`ARA_OFF_STAT, 32'h1);
        // channel change restarts the acquisition wait
        wr(`ARA_OFF_CTRL, 32'h16);
        chk({31'h0, acq_elapsed}, 32'h0);
        chk({27'h0, input_channel_select}, 32'h0B);
        repeat (ACQ - 1) @(posedge hclk);
        chk({31'h0, acq_elapsed}, 32'h0);
        @(posedge hclk);
        chk({31'h0, acq_elapsed}, 32'h1);
        wr(`ARA_OFF_CTRL, 32'h17);
        chk({31'h0, acq_elapsed}, 32'h1);
        chk({31'h0, result_format_select}, 32'h1);
        // conversion only after the acquisition wait has run out
        load(10'h2C3);
        rdchk(`ARA_OFF_HIGH, 32'h02);
        rdchk(`ARA_OFF_LOW, 32'hC3);
        wr(32'h0000_0010, 32'hFF);
        rdchk(32'h0000_0010, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire

// ==== shared/ara_defines.svh ====
// register map, field positions, reset values and timing counts
`ifndef ARA_DEFINES_SVH
`define ARA_DEFINES_SVH

// *****************************
// register byte addresses
// *****************************
`define ARA_OFF_HIGH 32'h0000_0000
`define ARA_OFF_LOW 32'h0000_0004
`define ARA_OFF_CTRL 32'h0000_0008
`define ARA_OFF_STAT 32'h0000_000C

// *****************************
// control and status fields
// *****************************
`define ARA_CTRL_FMT_BIT 0
`define ARA_CTRL_CHS_LSB 1
`define ARA_CTRL_CHS_MSB 5
`define ARA_STAT_ACQ_BIT 0
`define ARA_STAT_FRESH_BIT 1
`define ARA_FMT_RESET 1'h0
`define ARA_CHS_RESET 5'h00

// *****************************
// acquisition timing
// *****************************
`define ARA_ACQ_TIME_NS 4620
`define ARA_CLK_PERIOD_NS 25
`define ARA_ACQ_CYCLES ((`ARA_ACQ_TIME_NS + `ARA_CLK_PERIOD_NS - 1) / `ARA_CLK_PERIOD_NS)

`endif

// ==== shared/ara_pkg.sv ====
// shared types of the result alignment block
package ara_pkg;
    typedef logic [9:0] ara_result_t;
    typedef logic [7:0] ara_byte_t;
    typedef enum logic [2:0] {
        ARA_SEL_HIGH,
        ARA_SEL_LOW,
        ARA_SEL_CTRL,
        ARA_SEL_STAT,
        ARA_SEL_NONE
    } ara_sel_t;
endpackage
